/* File: logic/dual_clock_fifo_control.sv */
// dual-clock fifo control: flags, config load, replay, clears, mailbox
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module dual_clock_fifo_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        write_clk_i,
    input  wire logic        read_clk_i,
    input  wire logic        serial_clk_i,
    input  wire logic        serial_data_i,
    input  wire logic        serial_program_enable_i,
    input  wire logic        write_en_i,
    input  wire logic        read_en_i,
    input  wire logic        config_select_n_i,
    input  wire logic        replay_request_i,
    input  wire logic        mark_i,
    input  wire logic        mailbox_bypass_i,
    input  wire logic        master_clear_n_i,
    input  wire logic        partial_clear_n_i,
    input  wire logic [2:0]  word_width_select_i,
    input  wire logic [35:0] data_i,
    output logic      [35:0] data_o,
    output logic             output_valid_n_o,
    output logic             empty_flag_n_o,
    output logic             full_flag_n_o,
    output logic             almost_empty_flag_n_o,
    output logic             almost_full_flag_n_o,
    output logic             half_level_flag_n_o,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    localparam int SW = 52;
    localparam int PW = fifo_ctl_pkg::PW;
    // idle pin levels after reset: clears and config select inactive, so a blank
    // synchroniser never fakes a master clear that would latch a zero width code
    localparam logic [SW-1:0] SYNC_IDLE = 52'h0_0000_0000_008c;

    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [35:0]   d_s;
    logic [2:0]    ws_s;
    logic          wclk_s, rclk_s, sclk_s, wen_s, ren_s, cfg_n_s, mark_s;
    logic          rpl_s, mbox_s, mrs_n_s, prs_n_s, si_s, sen_s;
    logic          wclk_d_r, rclk_d_r, sclk_d_r, rpl_d_r;
    logic          wr_edge, rd_edge, sc_edge, rpl_rise, clr;

    // every link pin passes two flops, the wishbone pins none; edges are found on the second stage only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r     <= SYNC_IDLE;
            s2_r     <= SYNC_IDLE;
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            rpl_d_r  <= 1'b0;
        end
        else
        begin
            s1_r     <= {data_i, word_width_select_i, write_clk_i, read_clk_i, serial_clk_i,
                         write_en_i, read_en_i, config_select_n_i, mark_i, replay_request_i,
                         mailbox_bypass_i, master_clear_n_i, partial_clear_n_i, serial_data_i,
                         serial_program_enable_i};
            s2_r     <= s1_r;
            wclk_d_r <= wclk_s;
            rclk_d_r <= rclk_s;
            sclk_d_r <= sclk_s;
            rpl_d_r  <= rpl_s;
        end
    end

    assign {d_s, ws_s, wclk_s, rclk_s, sclk_s, wen_s, ren_s, cfg_n_s, mark_s, rpl_s,
            mbox_s, mrs_n_s, prs_n_s, si_s, sen_s} = s2_r;
    // data and strobes share the same sync delay, so they stay aligned
    assign wr_edge  = wclk_s & ~wclk_d_r;
    assign rd_edge  = rclk_s & ~rclk_d_r;
    assign sc_edge  = sclk_s & ~sclk_d_r;
    assign rpl_rise = rpl_s & ~rpl_d_r;
    assign clr      = ~mrs_n_s | ~prs_n_s;

    logic [35:0]   mem [fifo_ctl_pkg::DEPTH];
    logic [PW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, mark_r, mark_nxt, cnt, cnt_nxt;
    logic [7:0]    ae_ofs_r, ae_ofs_nxt, af_ofs_r, af_ofs_nxt;
    logic [2:0]    width_r, width_nxt;
    logic [35:0]   mbox_r, mbox_nxt, q_r, q_nxt, mask;
    logic          wsel_r, wsel_nxt, rsel_r, rsel_nxt, qv_n_r, qv_n_nxt;
    logic          empty_n_r, empty_n_nxt, full_n_r, full_n_nxt, ae_n_r, ae_n_nxt;
    logic          af_n_r, af_n_nxt, half_n_r, half_n_nxt, ack_r, ack_nxt, mem_we;
    logic [31:0]   dat_r, dat_nxt;
    logic [8:0]    af_sum;
    logic          wb_wr;

    assign cnt   = wptr_r - rptr_r;
    assign mask  = fifo_ctl_pkg::width_mask(width_r);
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];

    // next-state for pointers, config, output register and flags
    always_comb
    begin
        wptr_nxt    = wptr_r;
        rptr_nxt    = rptr_r;
        mark_nxt    = mark_r;
        ae_ofs_nxt  = ae_ofs_r;
        af_ofs_nxt  = af_ofs_r;
        width_nxt   = width_r;
        mbox_nxt    = mbox_r;
        q_nxt       = q_r;
        wsel_nxt    = wsel_r;
        rsel_nxt    = rsel_r;
        qv_n_nxt    = qv_n_r;
        empty_n_nxt = empty_n_r;
        full_n_nxt  = full_n_r;
        ae_n_nxt    = ae_n_r;
        af_n_nxt    = af_n_r;
        half_n_nxt  = half_n_r;
        mem_we      = 1'b0;
        cnt_nxt     = cnt;
        af_sum      = '0;
        if (clr)
        begin
            wptr_nxt    = '0;
            rptr_nxt    = '0;
            mark_nxt    = '0;
            q_nxt       = '0;
            qv_n_nxt    = 1'b1;
            wsel_nxt    = 1'b0;
            rsel_nxt    = 1'b0;
            empty_n_nxt = 1'b0;
            ae_n_nxt    = 1'b0;
            full_n_nxt  = 1'b1;
            af_n_nxt    = 1'b1;
            half_n_nxt  = 1'b1;
            if (!mrs_n_s)
            begin
                ae_ofs_nxt = fifo_ctl_pkg::AE_OFS_RST;
                af_ofs_nxt = fifo_ctl_pkg::AF_OFS_RST;
                width_nxt  = ws_s;
                mbox_nxt   = '0;
            end
        end
        else
        begin
            // software may retune offsets; it shares them with the pin paths
            if (wb_wr && wb_adr_i[3:2] == fifo_ctl_pkg::REG_AE)
                ae_ofs_nxt = wb_dat_i[7:0];
            if (wb_wr && wb_adr_i[3:2] == fifo_ctl_pkg::REG_AF)
                af_ofs_nxt = wb_dat_i[7:0];
            if (sen_s && sc_edge)
                {af_ofs_nxt, ae_ofs_nxt} = {af_ofs_r[6:0], ae_ofs_r, si_s};
            if (wr_edge && wen_s)
            begin
                if (mbox_s)
                    mbox_nxt = d_s & mask;
                else if (!cfg_n_s)
                begin
                    wsel_nxt = ~wsel_r;
                    if (wsel_r)
                        af_ofs_nxt = d_s[7:0];
                    else
                        ae_ofs_nxt = d_s[7:0];
                end
                else if (full_n_r)
                begin
                    mem_we   = 1'b1;
                    wptr_nxt = wptr_r + 1'b1;
                end
            end
            if (rd_edge)
            begin
                qv_n_nxt = 1'b1;
                if (mark_s)
                    // anchor before the read moves it
                    mark_nxt = rptr_r;
                if (ren_s)
                begin
                    if (mbox_s)
                    begin
                        q_nxt    = mbox_r;
                        qv_n_nxt = 1'b0;
                    end
                    else if (!cfg_n_s)
                    begin
                        rsel_nxt = ~rsel_r;
                        q_nxt    = {28'h0, rsel_r ? af_ofs_r : ae_ofs_r};
                        qv_n_nxt = 1'b0;
                    end
                    else if (empty_n_r)
                    begin
                        q_nxt    = mem[rptr_r[fifo_ctl_pkg::AW-1:0]] & mask;
                        rptr_nxt = rptr_r + 1'b1;
                        qv_n_nxt = 1'b0;
                    end
                end
            end
            // replay wins over a read in the same cycle
            if (rpl_rise)
                rptr_nxt = mark_r;
            // flags come from the pointer difference after this cycle
            cnt_nxt = wptr_nxt - rptr_nxt;
            af_sum  = {2'b00, cnt_nxt} + {1'b0, af_ofs_nxt};
            if (rd_edge)
            begin
                empty_n_nxt = cnt_nxt != '0;
                ae_n_nxt    = {1'b0, cnt_nxt} > ae_ofs_nxt;
            end
            if (wr_edge)
            begin
                full_n_nxt = cnt_nxt != fifo_ctl_pkg::FULL_CNT;
                af_n_nxt   = af_sum < {2'b00, fifo_ctl_pkg::FULL_CNT};
                half_n_nxt = cnt_nxt < fifo_ctl_pkg::HALF_CNT;
            end
        end
        if (clr)
        begin
            cnt_nxt = '0;
            af_sum  = '0;
        end
    end

    // wishbone answer one cycle after the request; unmapped reads give zero
    always_comb
    begin
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        dat_nxt = '0;
        case (wb_adr_i[3:2])
            fifo_ctl_pkg::REG_AE:   dat_nxt[7:0] = ae_ofs_r;
            fifo_ctl_pkg::REG_AF:   dat_nxt[7:0] = af_ofs_r;
            fifo_ctl_pkg::REG_STAT:
            begin
                dat_nxt[fifo_ctl_pkg::ST_EMPTY]                    = empty_n_r;
                dat_nxt[fifo_ctl_pkg::ST_FULL]                     = full_n_r;
                dat_nxt[fifo_ctl_pkg::ST_AE]                       = ae_n_r;
                dat_nxt[fifo_ctl_pkg::ST_AF]                       = af_n_r;
                dat_nxt[fifo_ctl_pkg::ST_HALF]                     = half_n_r;
                dat_nxt[fifo_ctl_pkg::ST_CNT+:PW]                  = cnt;
                dat_nxt[fifo_ctl_pkg::ST_WIDTH+:3]                 = width_r;
            end
            default:                dat_nxt = '0;
        endcase
    end

    // state registers; storage has no reset, its content is unreadable until written
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
            mem[wptr_r[fifo_ctl_pkg::AW-1:0]] <= d_s & mask;
        if (rst_i)
        begin
            wptr_r    <= '0;
            rptr_r    <= '0;
            mark_r    <= '0;
            ae_ofs_r  <= fifo_ctl_pkg::AE_OFS_RST;
            af_ofs_r  <= fifo_ctl_pkg::AF_OFS_RST;
            width_r   <= fifo_ctl_pkg::WIDTH_RST;
            mbox_r    <= '0;
            q_r       <= '0;
            wsel_r    <= 1'b0;
            rsel_r    <= 1'b0;
            qv_n_r    <= 1'b1;
            empty_n_r <= 1'b0;
            full_n_r  <= 1'b1;
            ae_n_r    <= 1'b0;
            af_n_r    <= 1'b1;
            half_n_r  <= 1'b1;
            ack_r     <= 1'b0;
            dat_r     <= '0;
        end
        else
        begin
            wptr_r    <= wptr_nxt;
            rptr_r    <= rptr_nxt;
            mark_r    <= mark_nxt;
            ae_ofs_r  <= ae_ofs_nxt;
            af_ofs_r  <= af_ofs_nxt;
            width_r   <= width_nxt;
            mbox_r    <= mbox_nxt;
            q_r       <= q_nxt;
            wsel_r    <= wsel_nxt;
            rsel_r    <= rsel_nxt;
            qv_n_r    <= qv_n_nxt;
            empty_n_r <= empty_n_nxt;
            full_n_r  <= full_n_nxt;
            ae_n_r    <= ae_n_nxt;
            af_n_r    <= af_n_nxt;
            half_n_r  <= half_n_nxt;
            ack_r     <= ack_nxt;
            dat_r     <= dat_nxt;
        end
    end

    assign data_o                = q_r;
    assign output_valid_n_o      = qv_n_r;
    assign empty_flag_n_o        = empty_n_r;
    assign full_flag_n_o         = full_n_r;
    assign almost_empty_flag_n_o = ae_n_r;
    assign almost_full_flag_n_o  = af_n_r;
    assign half_level_flag_n_o   = half_n_r;
    assign wb_dat_o              = dat_r;
    assign wb_ack_o              = ack_r;

    // checks on the block's own registers and outputs
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_live; mrs_n_s && prs_n_s; endsequence
    sequence s_fifo_rd;
        rd_edge && ren_s && cfg_n_s && !mbox_s && empty_n_r && !rpl_rise;
    endsequence

    a_empty_flag: assert property (s_live ##0 rd_edge |=> empty_n_r == (cnt != '0))
        else $error("empty flag disagrees with count");
    a_read_side_hold: assert property (s_live ##0 !rd_edge |=> $stable(empty_n_r) && $stable(ae_n_r))
        else $error("read-side flag moved without read edge");
    a_almost_empty: assert property (s_live ##0 rd_edge |=> ae_n_r == (cnt > $past(ae_ofs_nxt)))
        else $error("almost-empty flag wrong");
    a_full_half: assert property (s_live ##0 wr_edge |=>
        full_n_r == (cnt != fifo_ctl_pkg::FULL_CNT) && half_n_r == (cnt < fifo_ctl_pkg::HALF_CNT))
        else $error("full or half flag wrong");
    a_no_write_full: assert property (s_live ##0 !full_n_r ##0 !rpl_rise |=> $stable(wptr_r))
        else $error("write accepted while full");
    a_read_advance: assert property (s_live ##0 s_fifo_rd |=>
        rptr_r == PW'($past(rptr_r) + 1'b1) && !output_valid_n_o)
        else $error("fifo read did not advance or mark valid");
    a_replay_load: assert property (s_live ##0 rpl_rise |=> rptr_r == $past(mark_r))
        else $error("replay did not reload read pointer");
    a_mark_take: assert property (s_live ##0 rd_edge && mark_s |=> mark_r == $past(rptr_r))
        else $error("mark not recorded");
    a_master_clear: assert property (!mrs_n_s |=> wptr_r == '0 && rptr_r == '0 && q_r == '0
        && ae_ofs_r == fifo_ctl_pkg::AE_OFS_RST && width_r == $past(ws_s))
        else $error("master clear incomplete");
    a_partial_clear: assert property (mrs_n_s && !prs_n_s |=> wptr_r == '0 && q_r == '0
        && ae_ofs_r == $past(ae_ofs_r) && af_ofs_r == $past(af_ofs_r))
        else $error("partial clear wrong");
    a_valid_idle: assert property (s_live ##0 rd_edge && !ren_s |=> output_valid_n_o)
        else $error("valid without read");
endmodule // dual_clock_fifo_control

/* File: logic/fifo_ctl_pkg.sv */
// shared constants for the dual-clock fifo control block
package fifo_ctl_pkg;
    localparam int         DW         = 36;
    localparam int         AW         = 6;
    localparam int         DEPTH      = 64;
    localparam int         PW         = AW + 1;
    localparam logic [6:0] FULL_CNT   = 7'h40;
    localparam logic [6:0] HALF_CNT   = 7'h20;
    localparam logic [7:0] AE_OFS_RST = 8'h10;
    localparam logic [7:0] AF_OFS_RST = 8'h10;
    localparam logic [2:0] WIDTH_RST  = 3'h7;
    // word index on the wishbone bus (byte address = 4 * index)
    localparam logic [1:0] REG_AE     = 2'h0;
    localparam logic [1:0] REG_AF     = 2'h1;
    localparam logic [1:0] REG_STAT   = 2'h2;
    // status word fields
    localparam int         ST_EMPTY   = 0;
    localparam int         ST_FULL    = 1;
    localparam int         ST_AE      = 2;
    localparam int         ST_AF      = 3;
    localparam int         ST_HALF    = 4;
    localparam int         ST_CNT     = 8;
    localparam int         ST_WIDTH   = 16;

    // lane mask for the selected word width: x9 x12 x16 x18 x20 x24 x32 x36
    function automatic logic [35:0] width_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    width_mask = 36'h0_0000_01ff;
            3'h1:    width_mask = 36'h0_0000_0fff;
            3'h2:    width_mask = 36'h0_0000_ffff;
            3'h3:    width_mask = 36'h0_0003_ffff;
            3'h4:    width_mask = 36'h0_000f_ffff;
            3'h5:    width_mask = 36'h0_00ff_ffff;
            3'h6:    width_mask = 36'h0_ffff_ffff;
            default: width_mask = 36'hf_ffff_ffff;
        endcase
    endfunction
endpackage

/* File: verif/link_side_model.sv */
// far-side writer, reader and serial loader driving the fifo link pins
`timescale 1ns/1ns
module link_side_model (
    output logic        write_clk_o,
    output logic        read_clk_o,
    output logic        serial_clk_o,
    output logic        serial_data_o,
    output logic        serial_enable_o,
    output logic        write_en_o,
    output logic        read_en_o,
    output logic        mark_o,
    output logic [35:0] data_o
);
    // link clocks stand still between frames
    initial
    begin
        {write_clk_o, read_clk_o, serial_clk_o, serial_enable_o} = 4'h0;
        {write_en_o, read_en_o, mark_o, serial_data_o} = 4'h0;
        data_o = 36'h0;
    end
    // writer enables its edge
    // release three cycles after the rise, so a following call never meets it
    task automatic push(input logic [35:0] d);
        data_o     <= d;
        write_en_o <= 1'b1;
        #40 write_clk_o <= 1'b1;
        #24 write_en_o <= 1'b0;
        data_o     <= ~d; // released bus shows no stale word
        #16 write_clk_o <= 1'b0;
    endtask
    task automatic pull(input logic mk);
        read_en_o <= 1'b1;
        mark_o    <= mk;
        #40 read_clk_o <= 1'b1;
        #24 read_en_o <= 1'b0;
        mark_o    <= 1'b0;
        #16 read_clk_o <= 1'b0;
    endtask
    // enable held over all sixteen bits, msb first
    task automatic shift16(input logic [15:0] v);
        serial_enable_o <= 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            serial_data_o <= v[i];
            #40 serial_clk_o <= 1'b1;
            #40 serial_clk_o <= 1'b0;
        end
        serial_enable_o <= 1'b0;
        serial_data_o   <= ~v[0];
    endtask
endmodule // link_side_model

/* File: verif/dual_clock_fifo_control_test.sv */
// self-checking bench for the dual-clock fifo control block
`timescale 1ns/1ns
`define CHK(nm, e, g) chk(nm, e, g)
module dual_clock_fifo_control_test;
    typedef struct packed {logic we; logic [3:0] adr; logic [31:0] wd; logic [31:0] rd;} row_s;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        config_select_n_i, replay_request_i, mailbox_bypass_i, mark_i;
    logic        master_clear_n_i, partial_clear_n_i, write_en_i, read_en_i;
    logic        write_clk_i, read_clk_i, serial_clk_i, serial_data_i, serial_program_enable_i;
    logic        output_valid_n_o, empty_flag_n_o, full_flag_n_o, half_level_flag_n_o;
    logic        almost_empty_flag_n_o, almost_full_flag_n_o;
    logic [2:0]  word_width_select_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [35:0] data_i, data_o;
    int          fails = 0, n_tests = 0;
    logic [3:0]  sel_v = 4'hf;
    row_s        rows [10];

    dual_clock_fifo_control dut (
        .clk_i, .rst_i, .write_clk_i, .read_clk_i, .serial_clk_i, .serial_data_i,
        .serial_program_enable_i, .write_en_i, .read_en_i, .config_select_n_i,
        .replay_request_i, .mark_i, .mailbox_bypass_i, .master_clear_n_i,
        .partial_clear_n_i, .word_width_select_i, .data_i, .data_o, .output_valid_n_o,
        .empty_flag_n_o, .full_flag_n_o, .almost_empty_flag_n_o, .almost_full_flag_n_o,
        .half_level_flag_n_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o
    );
    link_side_model link (
        .write_clk_o(write_clk_i), .read_clk_o(read_clk_i), .serial_clk_o(serial_clk_i),
        .serial_data_o(serial_data_i), .serial_enable_o(serial_program_enable_i),
        .write_en_o(write_en_i), .read_en_o(read_en_i), .mark_o(mark_i), .data_o(data_i)
    );

    // system clock, 8 ns period
    always #4 clk_i = ~clk_i;

    // case equality so an unknown never matches
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one classic wishbone cycle; a hung slave ends the run
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_v;
        wb_dat_i <= d;
        k = 0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && k < 40)
        begin
            @(posedge clk_i);
            k++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k == 40)
        begin
            fails++;
            end_sim();
        end
    endtask
    // the selected clear pin (master or partial) held low four cycles, then let the flags settle
    task automatic clear(input logic master);
        @(posedge clk_i);
        master_clear_n_i  <= !master;
        partial_clear_n_i <= master;
        repeat (4) @(posedge clk_i);
        master_clear_n_i  <= 1'b1;
        partial_clear_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    function automatic logic [35:0] wd(input int i);
        return 36'h9_5a5a_5a00 ^ 36'(i);
    endfunction

    initial
    begin
        config_select_n_i   = 1'b1;
        master_clear_n_i    = 1'b1;
        partial_clear_n_i   = 1'b1;
        replay_request_i    = 1'b0;
        mailbox_bypass_i    = 1'b0;
        wb_cyc_i            = 1'b0;
        wb_stb_i            = 1'b0;
        wb_we_i             = 1'b0;
        word_width_select_i = 3'h7;
        wb_adr_i            = 4'h0;
        wb_sel_i            = 4'hf;
        wb_dat_i            = 32'h0;
        rows = '{'{1'b0, 4'h0, 32'h0, 32'h10}, '{1'b0, 4'h4, 32'h0, 32'h10},
                 '{1'b1, 4'h0, 32'hffff_ff05, 32'h0}, '{1'b1, 4'h4, 32'h3, 32'h0},
                 '{1'b1, 4'hc, 32'haa, 32'h0}, '{1'b1, 4'h8, 32'hffff, 32'h0},
                 '{1'b0, 4'h0, 32'h0, 32'h5}, '{1'b0, 4'h4, 32'h0, 32'h3},
                 '{1'b0, 4'hc, 32'h0, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h0007_001a}};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK("data_o", 36'h0, data_o);
        // register defaults, read-only and unmapped places
        foreach (rows[i])
        begin
            wb(rows[i].we, rows[i].adr, rows[i].wd);
            if (!rows[i].we)
                `CHK("wb_dat_o", rows[i].rd, q);
        end
        // a write with lane 0 off leaves the offset alone
        sel_v = 4'he;
        wb(1'b1, 4'h0, 32'h77);
        sel_v = 4'hf;
        wb(1'b0, 4'h0, 32'h0);
        `CHK("sel_off", 32'h5, q);
        $display("test registers done");
        // write-side levels follow each write; the 65th is refused
        for (int i = 1; i <= 65; i++)
        begin
            link.push(wd(i));
            `CHK("half_n", i < 32, half_level_flag_n_o);
            `CHK("af_n", i + 3 < 64, almost_full_flag_n_o);
            `CHK("full_n", i < 64, full_flag_n_o);
        end
        wb(1'b0, 4'h8, 32'h0);
        `CHK("status", 32'h0007_4000, q);
        $display("test fill done");
        // empty flag moves only on a read edge or a clear, so the first one is refused
        link.pull(1'b0);
        `CHK("refused", 1'b1, output_valid_n_o);
        // mark the second read, replay returns to it
        link.pull(1'b0);
        `CHK("data_o", wd(1), data_o);
        `CHK("valid_n", 1'b0, output_valid_n_o);
        link.pull(1'b1);
        link.pull(1'b0);
        @(posedge clk_i);
        replay_request_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        replay_request_i <= 1'b0;
        link.pull(1'b0);
        `CHK("replayed", wd(2), data_o);
        for (int j = 1; j <= 62; j++)
        begin
            link.pull(1'b0);
            `CHK("data_o", wd(j + 2), data_o);
            `CHK("ae_n", 62 - j > 5, almost_empty_flag_n_o);
            `CHK("empty_n", j != 62, empty_flag_n_o);
        end
        link.pull(1'b0);
        `CHK("valid_n", 1'b1, output_valid_n_o);
        $display("test drain done");
        // config path on the low byte, offsets alternate
        @(posedge clk_i);
        config_select_n_i <= 1'b0;
        link.push(36'hf_ffff_ff21);
        link.push(36'h0_0000_0032);
        link.pull(1'b0);
        `CHK("cfg_q", 8'h21, data_o[7:0]);
        link.pull(1'b0);
        `CHK("cfg_q", 8'h32, data_o[7:0]);
        @(posedge clk_i);
        config_select_n_i <= 1'b1;
        wb(1'b0, 4'h4, 32'h0);
        `CHK("af_ofs", 32'h32, q);
        link.shift16(16'h0a0b);
        wb(1'b0, 4'h0, 32'h0);
        `CHK("ae_ofs", 32'h0b, q);
        $display("test config done");
        link.push(wd(7));
        clear(1'b0);
        `CHK("data_o", 36'h0, data_o);
        wb(1'b0, 4'h0, 32'h0);
        `CHK("ae_ofs", 32'h0b, q);
        wb(1'b0, 4'h8, 32'h0);
        `CHK("status", 32'h0007_001a, q);
        // width taken only while master clear is low
        @(posedge clk_i);
        word_width_select_i <= 3'h0;
        clear(1'b1);
        word_width_select_i <= 3'h5;
        wb(1'b0, 4'h0, 32'h0);
        `CHK("ae_ofs", 32'h10, q);
        wb(1'b0, 4'h8, 32'h0);
        `CHK("width", 3'h0, q[18:16]);
        link.push(36'hf_ffff_ffff);
        link.pull(1'b0);
        `CHK("refused", 1'b1, output_valid_n_o);
        link.pull(1'b0);
        `CHK("masked", 36'h1ff, data_o);
        $display("test clears done");
        // mailbox carries a word past the storage
        @(posedge clk_i);
        mailbox_bypass_i <= 1'b1;
        link.push(36'h123);
        link.pull(1'b0);
        `CHK("mailbox", 36'h123, data_o);
        wb(1'b0, 4'h8, 32'h0);
        `CHK("count", 7'h0, q[14:8]);
        $display("test mailbox done");
        end_sim();
    end
endmodule // dual_clock_fifo_control_test
